// ---- hw/i2c_slave_map.svh ----
/*
  Register indices, field positions, reset values and fixed settings of the I2C slave status/buffer block.
  Assumes inclusion by bare name; byte address of a register is four times its index.
*/
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH

// Register indices
`define IDX_CONFIG        8'hE5
`define IDX_IRQ_ENABLE    8'hE6
`define IDX_BUS_STATUS    8'hE8
`define IDX_BYTE_BUFFER   8'hE9
`define IDX_IRQ_STATUS    8'hF8
`define IDX_IRQ_MASK      8'hF9

// Configuration fields
`define CFG_ENABLE_BIT    0
`define CFG_SOFT_RST_BIT  5
`define CFG_RESET         6'h10

// Peripheral interrupt enable field
`define IEN_SERIAL_BIT    3
`define IEN_RESET         8'h00

// Bus status fields
`define ST_START_BIT      7
`define ST_STOP_BIT       6
`define ST_DIR_BIT        5
`define ST_DATA_BIT       4
`define ST_FULL_BIT       3
`define ST_NACK_BIT       2
`define ST_WCOL_BIT       1
`define ST_OVR_BIT        0
`define ST_RESET          8'h44

// Event status and mask fields
`define EV_START_BIT      0
`define EV_STOP_BIT       1
`define EV_BYTE_BIT       2
`define EV_WCOL_BIT       3
`define EV_OVR_BIT        4
`define EV_WIDTH          5
`define EV_RESET          5'h00

`define BUF_RESET         8'h00

// Own 7-bit slave address, arbitrary default
`define OWN_ADDR          7'h2A

`endif

// ---- hw/i2c_slave_pkg.sv ----
/*
  Types shared by the I2C slave status/buffer block.
  Assumes nothing of its surroundings.
*/
package i2c_slave_pkg;

  // Gray order along address -> ack -> data -> ack
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_RX       = 3'b010,
    ST_RX_ACK   = 3'b110,
    ST_TX       = 3'b111,
    ST_TX_ACK   = 3'b101
  } eng_state_t;

  typedef logic [7:0] byte_t;

endpackage : i2c_slave_pkg

// ---- hw/i2c_bit_engine.sv ----
/*
  I2C slave bit engine: start/stop detection, address match, byte shifting and acknowledge handling.
  Assumes scl and sda already synchronous to clk_in and a master that drives the clock.
*/
`timescale 1ns/1ps
module i2c_bit_engine (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  // Control
  input  wire logic                  run_in,
  input  wire logic [6:0]            own_addr_in,
  input  wire i2c_slave_pkg::byte_t  tx_byte_in,
  // Bus pins
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       drive_low_out,
  // Events
  output logic                       ev_start_out,
  output logic                       ev_stop_out,
  output logic                       ev_addr_out,
  output logic                       rw_out,
  output logic                       ev_rx_out,
  output i2c_slave_pkg::byte_t       rx_byte_out,
  output logic                       ev_tx_done_out,
  output logic                       ev_ack_out,
  output logic                       nack_out,
  output logic                       tx_busy_out
);
  import i2c_slave_pkg::*;

  eng_state_t st_ff,  nxt_st;
  logic [2:0] cnt_ff, nxt_cnt;
  byte_t      sh_ff,  nxt_sh;
  logic       scl_q_ff, sda_q_ff, drv_ff, nxt_drv, got_ff, nxt_got, rw_ff, nxt_rw, nack_ff, nxt_nack;
  logic       ev_start_ff, ev_stop_ff, ev_addr_ff, ev_rx_ff, ev_txd_ff, ev_ack_ff;
  logic       nxt_ev_start, nxt_ev_stop, nxt_ev_addr, nxt_ev_rx, nxt_ev_txd, nxt_ev_ack;
  logic       rise, fall, start_c, stop_c;

  always_comb begin
    rise         = scl_in & ~scl_q_ff;
    fall         = ~scl_in & scl_q_ff;
    start_c      = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
    stop_c       = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
    nxt_st       = st_ff;
    nxt_cnt      = cnt_ff;
    nxt_sh       = sh_ff;
    nxt_drv      = drv_ff;
    nxt_got      = got_ff;
    nxt_rw       = rw_ff;
    nxt_nack     = nack_ff;
    nxt_ev_start = 1'b0;
    nxt_ev_stop  = 1'b0;
    nxt_ev_addr  = 1'b0;
    nxt_ev_rx    = 1'b0;
    nxt_ev_txd   = 1'b0;
    nxt_ev_ack   = 1'b0;
    if (!run_in) begin
      nxt_st  = ST_IDLE;
      nxt_drv = 1'b0;
      nxt_got = 1'b0;
      nxt_cnt = 3'h0;
    end else if (start_c) begin
      nxt_st       = ST_ADDR;
      nxt_cnt      = 3'h0;
      nxt_got      = 1'b0;
      nxt_drv      = 1'b0;
      nxt_ev_start = 1'b1;
    end else if (stop_c) begin
      nxt_st      = ST_IDLE;
      nxt_drv     = 1'b0;
      nxt_ev_stop = 1'b1;
    end else begin
      case (st_ff)
        ST_ADDR, ST_RX: begin
          if (rise) begin
            nxt_sh  = {sh_ff[6:0], sda_in};
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
              nxt_got   = 1'b1;
              nxt_ev_rx = (st_ff == ST_RX);
            end
          end else if (fall && got_ff) begin
            nxt_got = 1'b0;
            if (st_ff == ST_RX) begin
              nxt_drv = 1'b1;
              nxt_st  = ST_RX_ACK;
            end else if (sh_ff[7:1] == own_addr_in) begin
              nxt_ev_addr = 1'b1;
              nxt_rw      = sh_ff[0];
              nxt_drv     = 1'b1;
              nxt_st      = ST_ADDR_ACK;
            end else begin
              nxt_st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall) begin
            nxt_cnt = 3'h0;
            if (rw_ff) begin
              nxt_st  = ST_TX;
              nxt_sh  = tx_byte_in;
              nxt_drv = ~tx_byte_in[7];
            end else begin
              nxt_st  = ST_RX;
              nxt_drv = 1'b0;
            end
          end
        end
        ST_RX_ACK: begin
          if (fall) begin
            nxt_st  = ST_RX;
            nxt_drv = 1'b0;
          end
        end
        ST_TX: begin
          if (rise) begin
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
              nxt_got    = 1'b1;
              nxt_ev_txd = 1'b1;
            end
          end else if (fall) begin
            if (got_ff) begin
              nxt_got = 1'b0;
              nxt_drv = 1'b0;
              nxt_st  = ST_TX_ACK;
            end else begin
              nxt_sh  = {sh_ff[6:0], 1'b0};
              nxt_drv = ~sh_ff[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (rise) begin
            nxt_nack   = sda_in;
            nxt_ev_ack = 1'b1;
          end else if (fall) begin
            nxt_cnt = 3'h0;
            if (nack_ff) begin
              nxt_st = ST_IDLE;
            end else begin
              nxt_st  = ST_TX;
              nxt_sh  = tx_byte_in;
              nxt_drv = ~tx_byte_in[7];
            end
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff       <= ST_IDLE;
      cnt_ff      <= 3'h0;
      sh_ff       <= 8'h00;
      scl_q_ff    <= 1'b1;
      sda_q_ff    <= 1'b1;
      drv_ff      <= 1'b0;
      got_ff      <= 1'b0;
      rw_ff       <= 1'b0;
      nack_ff     <= 1'b1;
      ev_start_ff <= 1'b0;
      ev_stop_ff  <= 1'b0;
      ev_addr_ff  <= 1'b0;
      ev_rx_ff    <= 1'b0;
      ev_txd_ff   <= 1'b0;
      ev_ack_ff   <= 1'b0;
    end else begin
      st_ff       <= nxt_st;
      cnt_ff      <= nxt_cnt;
      sh_ff       <= nxt_sh;
      scl_q_ff    <= scl_in;
      sda_q_ff    <= sda_in;
      drv_ff      <= nxt_drv;
      got_ff      <= nxt_got;
      rw_ff       <= nxt_rw;
      nack_ff     <= nxt_nack;
      ev_start_ff <= nxt_ev_start;
      ev_stop_ff  <= nxt_ev_stop;
      ev_addr_ff  <= nxt_ev_addr;
      ev_rx_ff    <= nxt_ev_rx;
      ev_txd_ff   <= nxt_ev_txd;
      ev_ack_ff   <= nxt_ev_ack;
    end
  end

  assign drive_low_out  = drv_ff;
  assign ev_start_out   = ev_start_ff;
  assign ev_stop_out    = ev_stop_ff;
  assign ev_addr_out    = ev_addr_ff;
  assign rw_out         = rw_ff;
  assign ev_rx_out      = ev_rx_ff;
  assign rx_byte_out    = sh_ff;
  assign ev_tx_done_out = ev_txd_ff;
  assign ev_ack_out     = ev_ack_ff;
  assign nack_out       = nack_ff;
  assign tx_busy_out    = (st_ff == ST_TX) & ~got_ff;

endmodule : i2c_bit_engine

// ---- hw/i2c_slave_status_buffer.sv ----
/*
  I2C slave status and shared byte buffer with a classic Wishbone register slave and one level interrupt.
  Assumes a Wishbone master on clk_in, synchronous scl/sda inputs and an external master driving the clock.
*/
`timescale 1ns/1ps
`include "i2c_slave_map.svh"
module i2c_slave_status_buffer (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  // Wishbone slave
  input  wire logic         wb_cyc_in,
  input  wire logic         wb_stb_in,
  input  wire logic         wb_we_in,
  input  wire logic [11:0]  wb_adr_in,
  input  wire logic [3:0]   wb_sel_in,
  input  wire logic [31:0]  wb_dat_in,
  output logic      [31:0]  wb_dat_out,
  output logic              wb_ack_out,
  // I2C pins
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe_out,
  // Interrupt
  output logic              irq_out
);
  import i2c_slave_pkg::*;

  // Bus slave state
  logic        ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic        req, wr, rd, lane0;
  logic [7:0]  idx;

  // Software settings
  logic [5:0]           cfg_ff, nxt_cfg;
  logic [7:0]           ien_ff, nxt_ien;
  logic [`EV_WIDTH-1:0] mask_ff, nxt_mask;

  // Block state
  logic [7:0]           stat_ff, nxt_stat;
  byte_t                buf_ff, nxt_buf;
  logic [`EV_WIDTH-1:0] evst_ff, nxt_evst;
  logic                 irq_ff, nxt_irq;
  logic                 oe_ff;

  // Engine wires
  logic  active, drv, e_start, e_stop, e_addr, e_rw, e_rx, e_txd, e_ack, e_nack, tx_busy;
  byte_t rx_byte;
  logic  wcol_ev, ovr_ev, buf_rd;
  logic [`EV_WIDTH-1:0] ev_vec;

  // Interface held idle while disabled or in soft reset
  assign active = cfg_ff[`CFG_ENABLE_BIT] & ~cfg_ff[`CFG_SOFT_RST_BIT];

  i2c_bit_engine u_engine (
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .run_in         (active),
    .own_addr_in    (`OWN_ADDR),
    .tx_byte_in     (buf_ff),
    .scl_in         (scl_in),
    .sda_in         (sda_in),
    .drive_low_out  (drv),
    .ev_start_out   (e_start),
    .ev_stop_out    (e_stop),
    .ev_addr_out    (e_addr),
    .rw_out         (e_rw),
    .ev_rx_out      (e_rx),
    .rx_byte_out    (rx_byte),
    .ev_tx_done_out (e_txd),
    .ev_ack_out     (e_ack),
    .nack_out       (e_nack),
    .tx_busy_out    (tx_busy)
  );

  // Wishbone decode; answer one cycle after the request
  always_comb begin
    req   = wb_cyc_in & wb_stb_in & ~ack_ff;
    wr    = req & wb_we_in;
    rd    = req & ~wb_we_in;
    lane0 = wr & wb_sel_in[0] & (wb_adr_in[11:10] == 2'b00);
    idx   = wb_adr_in[9:2];
    nxt_ack  = req;
    nxt_rdat = 32'h0000_0000;
    if (rd && wb_adr_in[11:10] == 2'b00) begin
      case (idx)
        `IDX_CONFIG:      nxt_rdat = {26'h000_0000, cfg_ff};
        `IDX_IRQ_ENABLE:  nxt_rdat = {24'h00_0000, ien_ff};
        `IDX_BUS_STATUS:  nxt_rdat = {24'h00_0000, stat_ff};
        `IDX_BYTE_BUFFER: nxt_rdat = {24'h00_0000, buf_ff};
        `IDX_IRQ_STATUS:  nxt_rdat = {27'h000_0000, evst_ff};
        `IDX_IRQ_MASK:    nxt_rdat = {27'h000_0000, mask_ff};
        default:          nxt_rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // Software-written settings
  always_comb begin
    nxt_cfg  = cfg_ff;
    nxt_ien  = ien_ff;
    nxt_mask = mask_ff;
    if (lane0 && idx == `IDX_CONFIG) begin
      nxt_cfg = wb_dat_in[5:0];
    end
    if (lane0 && idx == `IDX_IRQ_ENABLE) begin
      nxt_ien = wb_dat_in[7:0];
    end
    if (lane0 && idx == `IDX_IRQ_MASK) begin
      nxt_mask = wb_dat_in[`EV_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_ff  <= `CFG_RESET;
      ien_ff  <= `IEN_RESET;
      mask_ff <= `EV_RESET;
    end else begin
      cfg_ff  <= nxt_cfg;
      ien_ff  <= nxt_ien;
      mask_ff <= nxt_mask;
    end
  end

  // Status flags, shared buffer and event bits
  always_comb begin
    buf_rd   = rd & (wb_adr_in[11:10] == 2'b00) & (idx == `IDX_BYTE_BUFFER);
    wcol_ev  = lane0 & (idx == `IDX_BYTE_BUFFER) & tx_busy;
    ovr_ev   = e_rx & stat_ff[`ST_FULL_BIT] & ~buf_rd;
    nxt_stat = stat_ff;
    nxt_buf  = buf_ff;
    nxt_evst = evst_ff;
    // Software clears the two sticky error flags by writing zero; a same-cycle event still sets them
    if (lane0 && idx == `IDX_BUS_STATUS) begin
      nxt_stat[`ST_WCOL_BIT] = stat_ff[`ST_WCOL_BIT] & wb_dat_in[`ST_WCOL_BIT];
      nxt_stat[`ST_OVR_BIT]  = stat_ff[`ST_OVR_BIT] & wb_dat_in[`ST_OVR_BIT];
    end
    if (lane0 && idx == `IDX_BYTE_BUFFER && !tx_busy) begin
      nxt_buf = wb_dat_in[7:0];
    end
    if (e_start) begin
      nxt_stat[`ST_START_BIT] = 1'b1;
      nxt_stat[`ST_STOP_BIT]  = 1'b0;
    end
    if (e_stop) begin
      nxt_stat[`ST_STOP_BIT]  = 1'b1;
      nxt_stat[`ST_START_BIT] = 1'b0;
    end
    if (e_addr) begin
      nxt_stat[`ST_DIR_BIT]  = e_rw;
      nxt_stat[`ST_DATA_BIT] = 1'b0;
    end
    if (e_rx || e_txd) begin
      nxt_stat[`ST_DATA_BIT] = 1'b1;
    end
    if (stat_ff[`ST_DIR_BIT]) begin
      nxt_stat[`ST_FULL_BIT] = tx_busy;
    end else begin
      if (buf_rd) begin
        nxt_stat[`ST_FULL_BIT] = 1'b0;
      end
      if (e_rx && !ovr_ev) begin
        nxt_stat[`ST_FULL_BIT] = 1'b1;
        nxt_buf                = rx_byte;
      end
    end
    if (e_ack) begin
      nxt_stat[`ST_NACK_BIT] = e_nack;
    end
    if (wcol_ev) begin
      nxt_stat[`ST_WCOL_BIT] = 1'b1;
    end
    if (ovr_ev) begin
      nxt_stat[`ST_OVR_BIT] = 1'b1;
    end
    // Event bits are write-one-to-clear, set wins
    if (lane0 && idx == `IDX_IRQ_STATUS) begin
      nxt_evst = evst_ff & ~wb_dat_in[`EV_WIDTH-1:0];
    end
    nxt_evst = nxt_evst | ev_vec;
    // Soft reset puts the flags back to their power-on values
    if (cfg_ff[`CFG_SOFT_RST_BIT]) begin
      nxt_stat = `ST_RESET;
    end
  end

  always_comb begin
    ev_vec                = '0;
    ev_vec[`EV_START_BIT] = e_start;
    ev_vec[`EV_STOP_BIT]  = e_stop;
    ev_vec[`EV_BYTE_BIT]  = e_addr | e_rx | e_txd;
    ev_vec[`EV_WCOL_BIT]  = wcol_ev;
    ev_vec[`EV_OVR_BIT]   = ovr_ev;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stat_ff <= `ST_RESET;
      buf_ff  <= `BUF_RESET;
      evst_ff <= `EV_RESET;
    end else begin
      stat_ff <= nxt_stat;
      buf_ff  <= nxt_buf;
      evst_ff <= nxt_evst;
    end
  end

  // Interrupt level, gated by the serial-bus enable
  always_comb begin
    nxt_irq = ien_ff[`IEN_SERIAL_BIT] & (|(evst_ff & mask_ff));
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
      oe_ff  <= drv & active; // Open drain: only ever pulls low
    end
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rdat_ff;
  assign irq_out    = irq_ff;
  assign sda_oe_out = oe_ff;
  assign sda_out    = 1'b0;

endmodule : i2c_slave_status_buffer

// ---- bench/i2c_master_model.sv ----
/* I2C bus master model that drives the clock, with start, stop and byte tasks.
   Assumes the bench resolves open-drain SDA with a pull-up. */
`timescale 1ns/1ps
module i2c_master_model (
  // Clock
  input  wire logic clk_in,
  // Bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  import i2c_slave_pkg::*;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Four clocks a half period, margin over the three needed
  task automatic half;
    repeat (4) @(posedge clk_in);
  endtask : half
  task automatic start;
    sda_out <= 1'b0;
    half();
    scl_out <= 1'b0;
  endtask : start
  task automatic stop;
    @(posedge clk_in);
    sda_out <= 1'b0;
    half();
    scl_out <= 1'b1;
    half();
    sda_out <= 1'b1;
    half();
  endtask : stop
  // SDA moves one clock after SCL falls, never while SCL is high
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk_in);
    sda_out <= b;
    half();
    scl_out <= 1'b1;
    half();
    r = sda_in;
    scl_out <= 1'b0;
  endtask : bit_io
  task automatic xfer(input byte_t d, input logic ack_in, output byte_t q, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack_out);
  endtask : xfer
endmodule : i2c_master_model

// ---- bench/i2c_slave_status_buffer_properties.sv ----
/* Port checker for the I2C slave status/buffer block.
   Assumes one clock; enable bits are shadowed from Wishbone writes. */
`timescale 1ns/1ps
`include "i2c_slave_map.svh"
module i2c_slave_status_buffer_properties (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  // Wishbone
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [11:0] wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  // Pins and interrupt
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  input wire logic        irq_out
);
  logic req, wr_ok, run_ff, nxt_run, ien_ff, nxt_ien;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  assign req   = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_ok = req && wb_we_in && wb_sel_in[0] && wb_adr_in[11:10] == 2'b00;
  // Shadow copies, since the internals are out of sight
  always_comb begin
    nxt_run = run_ff;
    nxt_ien = ien_ff;
    if (wr_ok && wb_adr_in[9:2] == `IDX_CONFIG) begin
      nxt_run = wb_dat_in[`CFG_ENABLE_BIT] && !wb_dat_in[`CFG_SOFT_RST_BIT];
    end
    if (wr_ok && wb_adr_in[9:2] == `IDX_IRQ_ENABLE) begin
      nxt_ien = wb_dat_in[`IEN_SERIAL_BIT];
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_ff <= 1'b0;
      ien_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      ien_ff <= nxt_ien;
    end
  end
  ack_after_req_a: assert property (req |=> wb_ack_out) else $error("no ack after request");
  ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  ack_has_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  dat_idle_zero_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
    else $error("read data outside ack");
  dat_upper_zero_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  sda_low_only_a: assert property (sda_out == 1'b0) else $error("sda driven high");
  oe_scl_low_a: assert property ($changed(sda_oe_out) |-> !scl_in) else $error("sda moved with scl high");
  oe_when_off_a: assert property (!run_ff [*2] |-> !sda_oe_out) else $error("drive while off");
  irq_gated_a: assert property (!ien_ff [*2] |-> !irq_out) else $error("irq while disabled");
  cover property ($rose(irq_out));
  cover property ($rose(sda_oe_out));
  cover property (wr_ok && wb_adr_in[9:2] == `IDX_BYTE_BUFFER);
endmodule : i2c_slave_status_buffer_properties

bind i2c_slave_status_buffer i2c_slave_status_buffer_properties u_props (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out));

// ---- bench/i2c_slave_status_buffer_tb.sv ----
/* Self-checking bench for the I2C slave status/buffer block.
   Assumes the master model and the bound port checker. */
`timescale 1ns/1ps
`include "i2c_slave_map.svh"
module i2c_slave_status_buffer_tb;
  import i2c_slave_pkg::*;
  logic        clk_in, arst_n_in, wb_cyc, wb_stb, wb_we, wb_ack, scl, m_sda, sda_o, sda_oe, irq, a;
  logic [11:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat;
  wire  logic  sda_w;
  int          failures, tests_run;
  byte_t       v, q, d;
  byte_t       rx_q[$];
  // Pull-up: either side may pull low
  assign sda_w = m_sda & ~(sda_oe & ~sda_o);
  always #12.5 clk_in = ~clk_in;
  i2c_slave_status_buffer u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat),
    .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .irq_out(irq));
  i2c_master_model u_m (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));
  task automatic chk(input byte_t got, input byte_t exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input byte_t idx, input byte_t wd, output byte_t rd);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {2'b00, idx, 2'b00};
    wb_wdat <= {24'h00_0000, wd};
    @(posedge clk_in);
    // No own limit: a missing ack is caught by the watchdog
    while (wb_ack !== 1'b1) begin
      @(posedge clk_in);
    end
    rd = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_in);
  endtask : wb
  task automatic rc(input byte_t idx, input byte_t mask, input byte_t exp);
    byte_t r;
    wb(1'b0, idx, 8'h00, r);
    chk(r & mask, exp);
  endtask : rc
  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Whole run needs well under a thousand cycles
  initial begin
    #500_000;
    failures++;
    tally_and_finish();
  end
  initial begin
    clk_in    = 1'b0;
    arst_n_in = 1'b0;
    wb_cyc    = 1'b0;
    wb_stb    = 1'b0;
    wb_we     = 1'b0;
    wb_adr    = 12'h000;
    wb_sel    = 4'hF;
    wb_wdat   = 32'h0000_0000;
    failures  = 0;
    tests_run = 0;
    d = byte_t'($urandom(32'h2a20_80bc));
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    rc(`IDX_BUS_STATUS, 8'hFF, `ST_RESET);
    rc(`IDX_BYTE_BUFFER, 8'hFF, `BUF_RESET);
    rc(8'h10, 8'hFF, 8'h00);
    wb(1'b1, `IDX_CONFIG, 8'h01, v);
    wb(1'b1, `IDX_IRQ_ENABLE, 8'h08, v);
    wb(1'b1, `IDX_IRQ_MASK, 8'h1F, v);
    // Write direction, second byte lands before the first is read
    u_m.start();
    u_m.xfer({`OWN_ADDR, 1'b0}, 1'b1, q, a);
    chk({7'h00, a}, 8'h00);
    rc(`IDX_BUS_STATUS, 8'hFB, 8'h80);
    d = byte_t'($urandom());
    rx_q.push_back(d);
    u_m.xfer(d, 1'b1, q, a);
    rc(`IDX_BUS_STATUS, 8'hFB, 8'h98);
    chk({7'h00, irq}, 8'h01);
    u_m.xfer(~d, 1'b1, q, a);
    rc(`IDX_BUS_STATUS, 8'hFB, 8'h99);
    rc(`IDX_BYTE_BUFFER, 8'hFF, rx_q.pop_front());
    wb(1'b1, `IDX_BUS_STATUS, 8'h00, v);
    rc(`IDX_BUS_STATUS, 8'hFB, 8'h90);
    u_m.stop();
    rc(`IDX_BUS_STATUS, 8'hFB, 8'h50);
    wb(1'b1, `IDX_IRQ_STATUS, 8'h1F, v);
    chk({7'h00, irq}, 8'h00);
    // Read direction, events pending while the enable is off
    d = byte_t'($urandom());
    wb(1'b1, `IDX_BYTE_BUFFER, d, v);
    wb(1'b1, `IDX_IRQ_ENABLE, 8'h00, v);
    u_m.start();
    u_m.xfer({`OWN_ADDR, 1'b1}, 1'b1, q, a);
    rc(`IDX_BUS_STATUS, 8'hE0, 8'hA0);
    chk({7'h00, irq}, 8'h00);
    wb(1'b1, `IDX_IRQ_ENABLE, 8'h08, v);
    chk({7'h00, irq}, 8'h01);
    fork
      u_m.xfer(8'hFF, 1'b0, q, a);
      begin
        repeat (24) @(posedge clk_in);
        wb(1'b1, `IDX_BYTE_BUFFER, ~d, v);
        rc(`IDX_BUS_STATUS, 8'h0A, 8'h0A);
      end
    join
    chk(q, d);
    rc(`IDX_BUS_STATUS, 8'h1C, 8'h10);
    u_m.xfer(8'hFF, 1'b1, q, a);
    chk(q, d);
    rc(`IDX_BUS_STATUS, 8'h04, 8'h04);
    u_m.stop();
    // Soft reset, then a disabled interface ignores its address
    wb(1'b1, `IDX_CONFIG, 8'h21, v);
    rc(`IDX_BUS_STATUS, 8'hFF, `ST_RESET);
    wb(1'b1, `IDX_CONFIG, 8'h00, v);
    u_m.start();
    u_m.xfer({`OWN_ADDR, 1'b0}, 1'b1, q, a);
    chk({7'h00, a}, 8'h01);
    rc(`IDX_BUS_STATUS, 8'hFF, `ST_RESET);
    u_m.stop();
    tally_and_finish();
  end
endmodule : i2c_slave_status_buffer_tb
